// ---- hdl/osc_sel_pkg.sv ----
// Purpose: Shared constants, types and helpers for the clock selection block
// Assumes: 32-bit AXI4-Lite data, 8-bit register address space
// Notes: Register offsets are byte addresses, one aligned word each
package osc_sel_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] ADDR_REQUEST = 8'h00; // Requested source and divider
  localparam logic [7:0] ADDR_CURRENT = 8'h04; // Active source and divider
  localparam logic [7:0] ADDR_CONTROL = 8'h08; // Switch control and flags
  localparam logic [7:0] ADDR_STATUS = 8'h0C; // Oscillator ready status
  localparam logic [7:0] ADDR_FORCE = 8'h10; // Manual enable bits
  localparam logic [7:0] ADDR_FLAG = 8'h14; // Switch flag, write one to clear

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int SRC_LSB = 4; // Source code field, bits 6..4
  localparam int DIV_LSB = 0; // Divider code field, bits 3..0
  localparam int HOLD_BIT = 7;
  localparam int SEC_HP_BIT = 6;
  localparam int SEC_BYP_BIT = 5;
  localparam int DONE_BIT = 4;
  localparam int NEW_RDY_BIT = 3;
  localparam int ST_EXT_BIT = 7; // Status and force bits share positions
  localparam int ST_FAST_BIT = 6;
  localparam int ST_SLOW_BIT = 4;
  localparam int ST_SEC_BIT = 3;
  localparam int ST_CONV_BIT = 2;
  localparam int ST_PLL_BIT = 0;
  localparam int FLAG_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Source codes and divider limit
  localparam logic [2:0] SRC_EXT = 3'h7;
  localparam logic [2:0] SRC_FAST_1M = 3'h6;
  localparam logic [2:0] SRC_RSVD_HI = 3'h5;
  localparam logic [2:0] SRC_SLOW = 3'h4;
  localparam logic [2:0] SRC_SEC = 3'h3;
  localparam logic [2:0] SRC_RSVD_LO = 3'h2;
  localparam logic [2:0] SRC_EXT_PLL = 3'h1;
  localparam logic [2:0] SRC_FAST_PLL = 3'h0;
  localparam logic [3:0] DIV_MAX_CODE = 4'h9; // Divide by 512

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [4:0] FORCE_RESET = 5'h00;
  localparam logic [3:0] DIV_RESET_FAST = 4'h2; // Used when reset source is 1 MHz
  localparam logic [3:0] DIV_RESET_OTHER = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: clock gate off time around a source change
  localparam int CLK_PERIOD_NS = 10;
  localparam int GATE_OFF_NS = 20;
  localparam int GATE_OFF_CYC = (GATE_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] GATE_CNT_LOAD = 2'(GATE_OFF_CYC - 1);

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Oscillator mask index: ext, fast, slow, secondary, converter
  localparam int OSC_EXT = 4;
  localparam int OSC_FAST = 3;
  localparam int OSC_SLOW = 2;
  localparam int OSC_SEC = 1;
  localparam int OSC_CONV = 0;
  typedef logic [4:0] osc_mask_t;

  // Switch sequencer states
  typedef enum logic [2:0] {SW_IDLE, SW_WAIT, SW_HOLD, SW_GATE_OFF, SW_SWAP, SW_GATE_ON}
    sw_state_e;

  // Oscillators a source code needs running
  function automatic osc_mask_t src_mask(input logic [2:0] code);
    osc_mask_t m;
    m = '0;
    case (code)
      SRC_EXT, SRC_EXT_PLL: m[OSC_EXT] = 1'b1;
      SRC_FAST_1M, SRC_FAST_PLL: m[OSC_FAST] = 1'b1;
      SRC_SLOW: m[OSC_SLOW] = 1'b1;
      SRC_SEC: m[OSC_SEC] = 1'b1;
      default: m = '0;
    endcase
    return m;
  endfunction

  // Source code goes through the PLL
  function automatic logic src_pll(input logic [2:0] code);
    return (code == SRC_EXT_PLL) || (code == SRC_FAST_PLL);
  endfunction

endpackage

// ---- hdl/osc_select_regs.sv ----
// Purpose: Clock source selection registers and glitch-free switch sequencer
// Assumes: Oscillator ready and request levels arrive from other domains
// Notes: Registers reached over AXI4-Lite, data in the low byte
// What this block does
// - Active source code read-only in bits 6..4
// - Active divider code read-only in bits 3..0
// - After reset active fields equal requested fields
// - Decode six source codes, two reserved
// - Divider codes select divide 1 to 512
// - External source runs configured oscillator mode
// - Hold bit suspends switch, flag raised, old clock
// - Without hold, switch when requested oscillator ready
// - High-power bit steers secondary unless bypassed
// - Bypass makes input pin a clock input
// - Switch-complete bit reads one when fields match
// - Requested-ready bit only while switching and ready
// - Status gives ready bit per oscillator
// - PLL ready needs enable, input, and lock
// - Force bits turn oscillators on
// - Forced oscillators use their configured modes
// - Unimplemented bits read as zero
// - Requested-ready sets switch interrupt flag too
// - Switch updates fields, clears requested-ready
// - Reserved requested source selects 1 MHz internal
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module osc_select_regs
  import osc_sel_pkg::*;
#(
  parameter logic [2:0] RESET_SOURCE = SRC_FAST_1M
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Oscillator side inputs, asynchronous levels
  input wire logic [4:0] osc_ready_raw,
  input wire logic pll_lock_raw,
  input wire logic [4:0] module_osc_request_raw,
  // Configuration from elsewhere on this clock
  input wire logic [2:0] external_osc_mode_config,
  input wire logic [3:0] fast_osc_frequency_select,
  // Oscillator controls
  output logic [4:0] osc_enable,
  output logic pll_enable,
  output logic pll_input_external,
  output logic [2:0] external_osc_mode,
  output logic [3:0] fast_osc_frequency,
  output logic secondary_osc_high_power,
  output logic secondary_osc_bypass,
  output logic secondary_osc_output_pin_en,
  // System clock selection
  output logic [2:0] sys_clock_source,
  output logic [3:0] sys_clock_divider,
  output logic sys_clock_gate,
  output logic switch_interrupt_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [2:0] req_src; // Requested source code
    logic [3:0] req_div; // Requested divider code
    logic [2:0] cur_src; // Active source code
    logic [3:0] cur_div; // Active divider code
    logic [2:0] tgt_src; // Target latched as the gate drops
    logic [3:0] tgt_div;
    logic hold; // Switch hold
    logic sec_hp; // Secondary high power
    logic sec_byp; // Secondary bypass
    logic new_rdy; // Requested oscillator ready during a switch
    logic sw_flag; // Switch interrupt flag
    logic [4:0] force_on; // Manual enables
    sw_state_e st;
    logic [1:0] cnt; // Gate phase counter
    logic gate; // System clock gate
    logic [7:0] status; // Ready status image
    logic [4:0] osc_en;
    logic pll_en;
    logic pll_ext;
    logic [2:0] ext_mode;
    logic [3:0] fast_freq;
    logic sec_hp_out;
    logic sec_byp_out;
    logic sec_drive;
    logic aw_full; // Write address held
    logic w_full; // Write data held
    logic [7:0] waddr;
    logic [7:0] wbyte;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s r_r;
  state_s r_nxt;

  // Synchronised oscillator inputs
  logic [4:0] ready_s;
  logic pll_lock_s;
  logic [4:0] request_s;

  // Combinational helpers
  logic in_prog;
  logic req_rdy;
  logic pll_in_ext;
  logic pll_on;
  logic pll_rdy;
  logic do_write;
  logic flag_set;
  logic flag_clr;
  logic [7:0] rd_val;
  logic rd_ok;
  logic [2:0] new_src;

  ////////////////////////////////////////////////////////////////////////////
  // Cross oscillator levels into the system clock
  sync2 #(.WIDTH(11)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({osc_ready_raw, pll_lock_raw, module_osc_request_raw}),
    .q({ready_s, pll_lock_s, request_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    r_nxt = r_r;
    flag_set = 1'b0;
    flag_clr = 1'b0;
    rd_val = 8'h00;
    rd_ok = 1'b1;
    new_src = SRC_FAST_1M;
    // A switch is pending while request and active differ
    in_prog = (r_r.req_src != r_r.cur_src) || (r_r.req_div != r_r.cur_div);
    // PLL input follows the active source when it uses the PLL
    pll_in_ext = src_pll(r_r.cur_src) ? (r_r.cur_src == SRC_EXT_PLL)
                                      : (r_r.req_src == SRC_EXT_PLL);
    pll_on = src_pll(r_r.cur_src) || (in_prog && src_pll(r_r.req_src));
    pll_rdy = pll_on && pll_lock_s
              && (pll_in_ext ? ready_s[OSC_EXT] : ready_s[OSC_FAST]);
    // Ready of the requested source
    case (r_r.req_src)
      SRC_EXT: req_rdy = ready_s[OSC_EXT];
      SRC_FAST_1M: req_rdy = ready_s[OSC_FAST];
      SRC_SLOW: req_rdy = ready_s[OSC_SLOW];
      SRC_SEC: req_rdy = ready_s[OSC_SEC];
      SRC_EXT_PLL, SRC_FAST_PLL: req_rdy = pll_rdy;
      default: req_rdy = 1'b0;
    endcase

    // Switch sequencer
    case (r_r.st)
      SW_IDLE: begin
        if (in_prog) begin
          r_nxt.st = SW_WAIT;
        end
      end
      SW_WAIT: begin
        if (!in_prog) begin
          r_nxt.st = SW_IDLE;
        end else if (req_rdy) begin
          r_nxt.new_rdy = 1'b1;
          flag_set = 1'b1;
          if (r_r.hold) begin
            r_nxt.st = SW_HOLD;
          end else begin
            r_nxt.st = SW_GATE_OFF;
            r_nxt.gate = 1'b0;
            r_nxt.cnt = GATE_CNT_LOAD;
            r_nxt.tgt_src = r_r.req_src;
            r_nxt.tgt_div = r_r.req_div;
          end
        end
      end
      SW_HOLD: begin
        // Old clock keeps running while held
        if (!in_prog) begin
          r_nxt.new_rdy = 1'b0;
          r_nxt.st = SW_IDLE;
        end else if (!req_rdy) begin
          r_nxt.new_rdy = 1'b0;
          r_nxt.st = SW_WAIT;
        end else if (!r_r.hold) begin
          r_nxt.st = SW_GATE_OFF;
          r_nxt.gate = 1'b0;
          r_nxt.cnt = GATE_CNT_LOAD;
          r_nxt.tgt_src = r_r.req_src;
          r_nxt.tgt_div = r_r.req_div;
        end
      end
      SW_GATE_OFF: begin
        // Let the old clock stop before the select moves
        if (r_r.cnt == 2'h0) begin
          r_nxt.st = SW_SWAP;
        end else begin
          r_nxt.cnt = r_r.cnt - 2'h1;
        end
      end
      SW_SWAP: begin
        r_nxt.cur_src = r_r.tgt_src;
        r_nxt.cur_div = r_r.tgt_div;
        r_nxt.new_rdy = 1'b0;
        r_nxt.cnt = GATE_CNT_LOAD;
        r_nxt.st = SW_GATE_ON;
      end
      SW_GATE_ON: begin
        // Settle the new select before the gate opens
        if (r_r.cnt == 2'h0) begin
          r_nxt.gate = 1'b1;
          r_nxt.st = SW_IDLE;
        end else begin
          r_nxt.cnt = r_r.cnt - 2'h1;
        end
      end
      default: begin
        r_nxt.st = SW_IDLE;
        r_nxt.gate = 1'b1;
      end
    endcase

    // Capture write address and data independently
    if (awvalid && r_r.awready) begin
      r_nxt.aw_full = 1'b1;
      r_nxt.waddr = awaddr;
    end
    if (wvalid && r_r.wready) begin
      r_nxt.w_full = 1'b1;
      r_nxt.wbyte = wdata[7:0];
      r_nxt.wstrb0 = wstrb[0];
    end
    if (r_r.bvalid && bready) begin
      r_nxt.bvalid = 1'b0;
    end

    // Register write once both halves are held
    do_write = r_r.aw_full && r_r.w_full && !r_r.bvalid;
    if (do_write) begin
      r_nxt.aw_full = 1'b0;
      r_nxt.w_full = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp = RESP_OKAY;
      // Reserved requested source falls back to 1 MHz internal
      new_src = r_r.wbyte[SRC_LSB +: 3];
      if (new_src == SRC_RSVD_HI || new_src == SRC_RSVD_LO) begin
        new_src = SRC_FAST_1M;
      end
      case (r_r.waddr)
        ADDR_REQUEST: begin
          if (r_r.wstrb0) begin
            r_nxt.req_src = new_src;
            r_nxt.req_div = r_r.wbyte[DIV_LSB +: 4];
          end
        end
        ADDR_CURRENT, ADDR_STATUS: begin
          // Read-only, write accepted and dropped
          r_nxt.bresp = RESP_OKAY;
        end
        ADDR_CONTROL: begin
          if (r_r.wstrb0) begin
            r_nxt.hold = r_r.wbyte[HOLD_BIT];
            r_nxt.sec_hp = r_r.wbyte[SEC_HP_BIT];
            r_nxt.sec_byp = r_r.wbyte[SEC_BYP_BIT];
          end
        end
        ADDR_FORCE: begin
          if (r_r.wstrb0) begin
            r_nxt.force_on = {r_r.wbyte[ST_EXT_BIT], r_r.wbyte[ST_FAST_BIT],
                              r_r.wbyte[ST_SLOW_BIT], r_r.wbyte[ST_SEC_BIT],
                              r_r.wbyte[ST_CONV_BIT]};
          end
        end
        ADDR_FLAG: begin
          flag_clr = r_r.wstrb0 && r_r.wbyte[FLAG_BIT];
        end
        default: begin
          r_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end
    // Requested-ready drops at once when a rewrite abandons the switch
    if ((r_nxt.req_src == r_nxt.cur_src) && (r_nxt.req_div == r_nxt.cur_div)) begin
      r_nxt.new_rdy = 1'b0;
    end
    r_nxt.awready = !r_nxt.aw_full && !r_nxt.bvalid;
    r_nxt.wready = !r_nxt.w_full && !r_nxt.bvalid;

    // Set wins over a clear in the same cycle
    r_nxt.sw_flag = (r_r.sw_flag && !flag_clr) || flag_set;

    // Read mux, unimplemented bits are zero
    case (araddr)
      ADDR_REQUEST: rd_val = {1'b0, r_r.req_src, r_r.req_div};
      ADDR_CURRENT: rd_val = {1'b0, r_r.cur_src, r_r.cur_div};
      ADDR_CONTROL: rd_val = {r_r.hold, r_r.sec_hp, r_r.sec_byp, !in_prog,
                              r_r.new_rdy, 3'h0};
      ADDR_STATUS: rd_val = r_r.status;
      ADDR_FORCE: rd_val = {r_r.force_on[OSC_EXT], r_r.force_on[OSC_FAST], 1'b0,
                            r_r.force_on[OSC_SLOW], r_r.force_on[OSC_SEC],
                            r_r.force_on[OSC_CONV], 2'h0};
      ADDR_FLAG: rd_val = {7'h00, r_r.sw_flag};
      default: rd_ok = 1'b0;
    endcase
    if (r_r.rvalid && rready) begin
      r_nxt.rvalid = 1'b0;
    end
    if (arvalid && r_r.arready) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rdata = 32'(rd_val);
      r_nxt.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    r_nxt.arready = !r_nxt.rvalid;

    // Ready status image
    r_nxt.status = '0;
    r_nxt.status[ST_EXT_BIT] = ready_s[OSC_EXT];
    r_nxt.status[ST_FAST_BIT] = ready_s[OSC_FAST];
    r_nxt.status[ST_SLOW_BIT] = ready_s[OSC_SLOW];
    r_nxt.status[ST_SEC_BIT] = ready_s[OSC_SEC];
    r_nxt.status[ST_CONV_BIT] = ready_s[OSC_CONV];
    r_nxt.status[ST_PLL_BIT] = pll_rdy;

    // Oscillator enables: forced, requested by modules, or needed by a source
    r_nxt.osc_en = r_r.force_on | request_s | src_mask(r_r.cur_src)
                   | (in_prog ? src_mask(r_r.req_src) : 5'h00);
    r_nxt.pll_en = pll_on;
    r_nxt.pll_ext = pll_in_ext;
    r_nxt.ext_mode = external_osc_mode_config;
    r_nxt.fast_freq = fast_osc_frequency_select;
    r_nxt.sec_hp_out = r_r.sec_hp && !r_r.sec_byp;
    r_nxt.sec_byp_out = r_r.sec_byp;
    r_nxt.sec_drive = !r_r.sec_byp;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_r <= '0;
      r_r.req_src <= RESET_SOURCE;
      r_r.req_div <= (RESET_SOURCE == SRC_FAST_1M) ? DIV_RESET_FAST : DIV_RESET_OTHER;
      r_r.cur_src <= RESET_SOURCE;
      r_r.cur_div <= (RESET_SOURCE == SRC_FAST_1M) ? DIV_RESET_FAST : DIV_RESET_OTHER;
      r_r.hold <= CONTROL_RESET[HOLD_BIT];
      r_r.sec_hp <= CONTROL_RESET[SEC_HP_BIT];
      r_r.sec_byp <= CONTROL_RESET[SEC_BYP_BIT];
      r_r.force_on <= FORCE_RESET;
      r_r.st <= SW_IDLE;
      r_r.gate <= 1'b1;
      r_r.sec_drive <= 1'b1;
      r_r.awready <= 1'b1;
      r_r.wready <= 1'b1;
      r_r.arready <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign awready = r_r.awready;
  assign wready = r_r.wready;
  assign bvalid = r_r.bvalid;
  assign bresp = r_r.bresp;
  assign arready = r_r.arready;
  assign rvalid = r_r.rvalid;
  assign rdata = r_r.rdata;
  assign rresp = r_r.rresp;
  assign osc_enable = r_r.osc_en;
  assign pll_enable = r_r.pll_en;
  assign pll_input_external = r_r.pll_ext;
  assign external_osc_mode = r_r.ext_mode;
  assign fast_osc_frequency = r_r.fast_freq;
  assign secondary_osc_high_power = r_r.sec_hp_out;
  assign secondary_osc_bypass = r_r.sec_byp_out;
  assign secondary_osc_output_pin_en = r_r.sec_drive;
  assign sys_clock_source = r_r.cur_src;
  assign sys_clock_divider = r_r.cur_div;
  assign sys_clock_gate = r_r.gate;
  assign switch_interrupt_flag = r_r.sw_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  localparam int SW_BOUND = 8; // Gate drop to swap, upper bound
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Ready seen while switching without hold
  sequence ready_no_hold;
    r_r.st == SW_WAIT && in_prog && req_rdy && !r_r.hold;
  endsequence

  // Swap stage reached with the gate closed
  sequence swap_closed;
    r_r.st == SW_SWAP && !r_r.gate;
  endsequence

  cur_fixed_a: assert property ((r_r.st != SW_SWAP) |=>
    $stable(r_r.cur_src) && $stable(r_r.cur_div))
    else $error("active fields moved outside a swap");
  reset_match_a: assert property ($rose(aresetn) |->
    (r_r.cur_src == r_r.req_src) && (r_r.cur_div == r_r.req_div))
    else $error("active fields differ from request after reset");
  no_reserved_a: assert property ((r_r.req_src != SRC_RSVD_HI)
    && (r_r.req_src != SRC_RSVD_LO))
    else $error("reserved source stored in request");
  hold_keeps_a: assert property ((r_r.st == SW_HOLD && r_r.hold) |=>
    $stable(r_r.cur_src) && r_r.gate)
    else $error("held switch changed the clock");
  switch_go_a: assert property (ready_no_hold |=>
    !r_r.gate ##[1:SW_BOUND] swap_closed)
    else $error("switch did not proceed when ready");
  glitch_free_a: assert property (($changed(r_r.cur_src) || $changed(r_r.cur_div))
    |-> !r_r.gate && !$past(r_r.gate))
    else $error("clock select moved with gate open");
  requested_osc_ready_flag_only_a: assert property (r_r.new_rdy |-> in_prog)
    else $error("requested-ready set with no switch");
  flag_with_a: assert property ($rose(r_r.new_rdy) |-> r_r.sw_flag)
    else $error("flag not raised with requested-ready");
  swap_done_a: assert property (r_r.st == SW_SWAP |=>
    !r_r.new_rdy && (r_r.cur_src == $past(r_r.tgt_src)))
    else $error("swap did not update fields");
  pll_off_a: assert property (!pll_on |=> !r_r.status[ST_PLL_BIT])
    else $error("pll ready while disabled");
  force_on_a: assert property (1'b1 |=>
    ((r_r.osc_en & $past(r_r.force_on)) == $past(r_r.force_on)))
    else $error("forced oscillator not enabled");
  bypass_hp_a: assert property (r_r.sec_byp |=> !r_r.sec_hp_out)
    else $error("high power active in bypass");
  read_zero_a: assert property (r_r.rvalid |-> r_r.rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");

endmodule

// ---- hdl/sync2.sv ----
// Purpose: Two flip-flop synchroniser for a vector of independent levels
// Assumes: Each bit is a slow level, not a bus word
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r; // First stage, read only by q

  // Two stage capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ---- tb/osc_model.sv ----
// Purpose: Behavioural oscillators and PLL answering their enables
// Assumes: Ready follows an enable after START_CYC cycles
// Notes: Ready drops at once when the enable drops
`timescale 1ns/10ps
module osc_model #(
  parameter int START_CYC = 6
) (
  // Clock
  input wire logic aclk,
  // Enables from the block
  input wire logic [4:0] osc_enable,
  input wire logic pll_enable,
  // Ready levels back
  output logic [4:0] osc_ready_raw,
  output logic pll_lock_raw
);
  int cnt [6];
  // Start-up counters, index 5 is the PLL
  always @(posedge aclk) begin
    for (int i = 0; i < 6; i++) begin
      if (!(i == 5 ? pll_enable : osc_enable[i])) cnt[i] <= 0;
      else if (cnt[i] < START_CYC) cnt[i] <= cnt[i] + 1;
    end
  end
  // Ready only while enabled and started
  always_comb begin
    for (int i = 0; i < 5; i++) osc_ready_raw[i] = osc_enable[i] && cnt[i] >= START_CYC;
    pll_lock_raw = pll_enable && cnt[5] >= START_CYC;
  end
endmodule

// ---- tb/oscillator_select_status_regs_test.sv ----
// Purpose: Self-checking bench for the clock selection registers
// Assumes: Bus and switch timing as the design states
// Notes: Oscillators come from osc_model
`timescale 1ns/10ps
module oscillator_select_status_regs_test
  import osc_sel_pkg::*;
;
  // Bus signals
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  // Oscillator side
  logic [4:0] osc_rdy, osc_en;
  logic pll_lock, pll_en, hp, byp, pin_en, irq, pll_ext, gate;
  logic [4:0] mreq;
  logic [2:0] cfg_mode;
  logic [3:0] cfg_frq;
  int gate_lo = 0;
  logic [2:0] ext_mode, src;
  logic [3:0] frq, div;
  int miscompares = 0;
  int num_checks = 0;

  osc_select_regs uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .osc_ready_raw(osc_rdy), .pll_lock_raw(pll_lock), .module_osc_request_raw(mreq),
    .external_osc_mode_config(cfg_mode), .fast_osc_frequency_select(cfg_frq),
    .osc_enable(osc_en), .pll_enable(pll_en), .pll_input_external(pll_ext),
    .external_osc_mode(ext_mode), .fast_osc_frequency(frq), .secondary_osc_high_power(hp),
    .secondary_osc_bypass(byp), .secondary_osc_output_pin_en(pin_en), .sys_clock_source(src),
    .sys_clock_divider(div), .sys_clock_gate(gate), .switch_interrupt_flag(irq));
  osc_model #(.START_CYC(12)) osc (.aclk(aclk), .osc_enable(osc_en), .pll_enable(pll_en),
    .osc_ready_raw(osc_rdy), .pll_lock_raw(pll_lock));
  // Count edges with the system clock gated off
  always @(posedge aclk) if (aresetn && !gate) gate_lo <= gate_lo + 1;

  ////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (++n > 50) begin
        miscompares++;
        final_report();
      end
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  // Bus read
  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (++n > 50) begin
        miscompares++;
        final_report();
      end
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // Read until the value appears, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      rdr(a);
      n++;
    end while (rd !== exp && n < 100);
    chk(rd, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rdr(ADDR_CURRENT);
    chk(rd, 32'h0000_0062);
    rdr(ADDR_CONTROL);
    chk(rd, 32'h0000_0010);
    chk(ext_mode, 3'h5);
    chk(frq, 4'h6);
    wr(ADDR_CURRENT, 32'h0000_0011);
    rdr(ADDR_CURRENT);
    chk(rd, 32'h0000_0062);
    rdr(8'h18);
    chk(resp, 2'h2);
    chk(rd, 32'h0000_0000);
    rdr(ADDR_REQUEST);
    chk(rd, 32'h0000_0062);
  endtask
  task automatic t_switch();
    wr(ADDR_REQUEST, 32'h0000_0040);
    poll(ADDR_CURRENT, 32'h0000_0040);
    chk(src, 3'h4);
    rdr(ADDR_CONTROL);
    chk(rd, 32'h0000_0010);
    chk(gate_lo, 2 * GATE_OFF_CYC + 1);
    rdr(ADDR_FLAG);
    chk({rd[0], irq}, 2'h3);
    wr(ADDR_FLAG, 32'h0000_0001);
    rdr(ADDR_FLAG);
    chk(rd, 32'h0000_0000);
  endtask
  task automatic t_hold();
    wr(ADDR_CONTROL, 32'h0000_0080);
    wr(ADDR_REQUEST, 32'h0000_0035);
    poll(ADDR_CONTROL, 32'h0000_0088);
    chk(src, 3'h4);
    chk(gate, 1'b1);
    wr(ADDR_CONTROL, 32'h0000_0000);
    poll(ADDR_CURRENT, 32'h0000_0035);
    chk(div, 4'h5);
  endtask
  task automatic t_reserved();
    wr(ADDR_REQUEST, 32'h0000_0055);
    rdr(ADDR_REQUEST);
    chk(rd, 32'h0000_0065);
    poll(ADDR_CURRENT, 32'h0000_0065);
    wr(ADDR_REQUEST, 32'h0000_0027);
    rdr(ADDR_REQUEST);
    chk(rd, 32'h0000_0067);
    poll(ADDR_CURRENT, 32'h0000_0067);
  endtask
  task automatic t_pll_force();
    wr(ADDR_REQUEST, 32'h0000_0009);
    poll(ADDR_CURRENT, 32'h0000_0009);
    poll(ADDR_STATUS, 32'h0000_0041);
    chk({pll_en, pll_ext}, 2'b10);
    mreq <= 5'h01;
    poll(ADDR_STATUS, 32'h0000_0045);
    wr(ADDR_FORCE, 32'h0000_00FF);
    rdr(ADDR_FORCE);
    chk(rd, 32'h0000_00DC);
    poll(ADDR_STATUS, 32'h0000_00DD);
    chk(osc_en, 5'h1F);
    wr(ADDR_REQUEST, 32'h0000_0010);
    poll(ADDR_CURRENT, 32'h0000_0010);
    chk(pll_ext, 1'b1);
    wr(ADDR_REQUEST, 32'h0000_0070);
    poll(ADDR_CURRENT, 32'h0000_0070);
    chk(pll_en, 1'b0);
    rdr(ADDR_STATUS);
    chk(rd, 32'h0000_00DC);
  endtask
  task automatic t_secondary();
    cfg_mode <= 3'h2;
    cfg_frq <= 4'h3;
    wr(ADDR_CONTROL, 32'h0000_0060);
    rdr(ADDR_CONTROL);
    chk(rd, 32'h0000_0070);
    chk({hp, byp, pin_en}, 3'b010);
    wr(ADDR_CONTROL, 32'h0000_0040);
    rdr(ADDR_CONTROL);
    chk(rd, 32'h0000_0050);
    chk({hp, byp, pin_en}, 3'b101);
    chk({ext_mode, frq}, 7'h23);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock and main sequence
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'h1;
    mreq = 5'h00;
    cfg_mode = 3'h5;
    cfg_frq = 4'h6;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_switch();
    t_hold();
    t_reserved();
    t_pll_force();
    t_secondary();
    final_report();
  end
endmodule
